// ### verilog/sfrc_map.vh
// constants for the serial flash register command block
`ifndef SFRC_MAP_VH
`define SFRC_MAP_VH

// command codes
`define SFRC_CMD_WR_EN      8'h06
`define SFRC_CMD_WR_DIS     8'h04
`define SFRC_CMD_RD_STATUS  8'h05
`define SFRC_CMD_RD_FLAG    8'h70
`define SFRC_CMD_RD_NVCFG   8'hB5
`define SFRC_CMD_RD_VCFG    8'h85
`define SFRC_CMD_RD_ECFG    8'h65
`define SFRC_CMD_WR_STATUS  8'h01
`define SFRC_CMD_WR_NVCFG   8'hB1
`define SFRC_CMD_WR_VCFG    8'h81
`define SFRC_CMD_WR_ECFG    8'h61
`define SFRC_CMD_CLR_FLAG   8'h50

// link protocol modes
`define SFRC_MODE_EXT       2'h0
`define SFRC_MODE_DUAL      2'h1
`define SFRC_MODE_QUAD      2'h2

// status register fields
`define SFRC_SR_WIP         0
`define SFRC_SR_WEL         1
`define SFRC_SR_LOCK        7
`define SFRC_SR_RST         6'h00

// flag status register fields
`define SFRC_FS_READY       7
`define SFRC_FS_ERASE       5
`define SFRC_FS_PROG        4
`define SFRC_FS_PROT        1

// configuration reset values and reserved masks
`define SFRC_NVCFG_RST      16'hFFFF
`define SFRC_NVCFG_RSV      16'h000C
`define SFRC_VCFG_RST       8'hFB
`define SFRC_VCFG_RSV       8'h04
`define SFRC_ECFG_RST       8'hDF
`define SFRC_ECFG_RSV       8'h20

// bit counting
`define SFRC_BYTE_BITS      6'h08
`define SFRC_NVCFG_BITS     6'h10
`define SFRC_BIT_SAT        6'h38
`define SFRC_IDX_SAT        2'h3

// timing
`define SFRC_CLK_PERIOD_NS  10
`define SFRC_CNT_DONE       24'h000001

`endif

// ### verilog/sfrc_sync.v
// two flip-flop synchroniser for the link pins
`timescale 1ns/1ps
`default_nettype none

module sfrc_sync #(
  parameter W = 11
) (
  // clock and reset
  input  wire         ref_clk,
  input  wire         rst,
  // raw and synchronised levels
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] stage1;

  always @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= {W{1'b1}};
      dout   <= {W{1'b1}};
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

`default_nettype wire

// ### verilog/sfrc_top.v
// register command engine for a two-die serial flash link
`timescale 1ns/1ps
`default_nettype none
`include "sfrc_map.vh"

module sfrc_top #(
  parameter STATUS_WRITE_TIME_NS = 50000,
  parameter CONFIG_WRITE_TIME_NS = 80000
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // link pins
  input  wire        linkClk,
  input  wire        chipSelN,
  input  wire [7:0]  dqIn,
  output wire [7:0]  dqOut,
  output wire [7:0]  dqOe,
  input  wire        writeProtN,
  // protocol mode shared by both dies, and array events one bit per die
  input  wire [1:0]  protoMode,
  input  wire [1:0]  memBusy,
  input  wire [1:0]  eraseErr,
  input  wire [1:0]  progErr,
  // register contents, die 1 in the upper half
  output wire [15:0] regStatus,
  output wire [15:0] regFlag,
  output wire [31:0] cfgNv,
  output wire [15:0] cfgVol,
  output wire [15:0] cfgEnh
);

  // ==========================================================
  // constants
  localparam [2:0] ST_SKIP  = 3'h0;
  localparam [2:0] ST_CMD   = 3'h1;
  localparam [2:0] ST_NOARG = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_READ  = 3'h4;

  localparam integer TW_CYC = (STATUS_WRITE_TIME_NS +
    `SFRC_CLK_PERIOD_NS - 1) / `SFRC_CLK_PERIOD_NS;
  localparam integer TNV_CYC = (CONFIG_WRITE_TIME_NS +
    `SFRC_CLK_PERIOD_NS - 1) / `SFRC_CLK_PERIOD_NS;

  // ==========================================================
  // lane helpers
  function [3:0] stepOf;
    input [1:0] mode;
    begin
      case (mode)
        `SFRC_MODE_DUAL: stepOf = 4'h2;
        `SFRC_MODE_QUAD: stepOf = 4'h4;
        default:         stepOf = 4'h1;
      endcase
    end
  endfunction

  function [7:0] shiftIn;
    input [7:0] sr;
    input [3:0] lanes;
    input [1:0] mode;
    begin
      case (mode)
        `SFRC_MODE_DUAL: shiftIn = {sr[5:0], lanes[1:0]};
        `SFRC_MODE_QUAD: shiftIn = {sr[3:0], lanes};
        default:         shiftIn = {sr[6:0], lanes[0]};
      endcase
    end
  endfunction

  function [3:0] outBits;
    input [7:0] sr;
    input [1:0] mode;
    begin
      case (mode)
        `SFRC_MODE_DUAL: outBits = {2'h0, sr[7:6]};
        `SFRC_MODE_QUAD: outBits = sr[7:4];
        default:         outBits = {2'h0, sr[7], 1'b0};
      endcase
    end
  endfunction

  function [3:0] oeMask;
    input [1:0] mode;
    begin
      case (mode)
        `SFRC_MODE_DUAL: oeMask = 4'h3;
        `SFRC_MODE_QUAD: oeMask = 4'hF;
        default:         oeMask = 4'h2;
      endcase
    end
  endfunction

  function [7:0] shiftOut;
    input [7:0] sr;
    input [1:0] mode;
    begin
      case (mode)
        `SFRC_MODE_DUAL: shiftOut = {sr[5:0], 2'h0};
        `SFRC_MODE_QUAD: shiftOut = {sr[3:0], 4'h0};
        default:         shiftOut = {sr[6:0], 1'b0};
      endcase
    end
  endfunction

  // byte number idx of a register read
  function [7:0] readByte;
    input [7:0]  code;
    input [1:0]  idx;
    input [7:0]  sr;
    input [7:0]  fs;
    input [15:0] nv;
    input [7:0]  vc;
    input [7:0]  ec;
    reg   [15:0] rsv;
    begin
      rsv = `SFRC_NVCFG_RSV;
      case (code)
        `SFRC_CMD_RD_STATUS: readByte = sr;
        `SFRC_CMD_RD_FLAG:   readByte = fs;
        `SFRC_CMD_RD_NVCFG: begin
          if (idx == 2'h0)
            readByte = nv[7:0] | rsv[7:0];
          else if (idx == 2'h1)
            readByte = nv[15:8] | rsv[15:8];
          else
            readByte = 8'h00;
        end
        `SFRC_CMD_RD_VCFG:   readByte = vc;
        `SFRC_CMD_RD_ECFG:   readByte = ec;
        default:             readByte = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================
  // pin synchronisation and edge detection
  wire [10:0] syncOut;
  wire        clkS;
  wire        csS;
  wire        wpS;
  wire [7:0]  dqS;
  reg         clkD;
  reg         csD;

  sfrc_sync #(
    .W (11)
  ) uSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     ({linkClk, chipSelN, writeProtN, dqIn}),
    .dout    (syncOut)
  );

  assign clkS = syncOut[10];
  assign csS  = syncOut[9];
  assign wpS  = syncOut[8];
  assign dqS  = syncOut[7:0];

  always @(posedge ref_clk) begin
    if (rst) begin
      // match the synchroniser's reset level, no false edge at release
      clkD <= 1'b1;
      csD  <= 1'b1;
    end else begin
      clkD <= clkS;
      csD  <= csS;
    end
  end

  wire linkRise = clkS & ~clkD & ~csS;
  wire linkFall = ~clkS & clkD & ~csS;
  wire csFall   = ~csS & csD;
  wire csRise   = csS & ~csD;
  wire [3:0] step = stepOf(protoMode);

  // ==========================================================
  // per-die engines
  genvar d;
  generate
    // same command on each lane group
    for (d = 0; d < 2; d = d + 1) begin : gDie
      reg [2:0]  state;
      reg [7:0]  cmd;
      reg [7:0]  inSr;
      reg [5:0]  bitCnt;
      reg [7:0]  dataLo;
      reg [7:0]  dataHi;
      reg [7:0]  outSr;
      reg [2:0]  outCnt;
      reg [1:0]  outIdx;
      reg [3:0]  doutR;
      reg [3:0]  oeR;
      reg [7:2]  srHi;
      reg        wel;
      reg        wip;
      reg        busyNv;
      reg [23:0] busyCnt;
      reg        fsErase;
      reg        fsProg;
      reg        fsProt;
      reg [15:0] nvReg;
      reg [7:0]  vcReg;
      reg [7:0]  ecReg;

      wire [3:0] lanesIn = dqS[4*d+3:4*d];
      wire [7:0] nextIn  = shiftIn(inSr, lanesIn, protoMode);
      wire [5:0] bitSum  = bitCnt + {2'h0, step};
      wire       byteEnd = (bitSum[2:0] == 3'h0);
      wire [3:0] outSum  = {1'b0, outCnt} + step;
      wire [7:0] status  = {srHi, wel, wip | memBusy[d]};
      wire [7:0] flag    = {~(wip | memBusy[d]), 1'b0, fsErase,
                            fsProg, 2'h0, fsProt, 1'b0};
      wire       cmdDone = linkRise & (state == ST_CMD) & byteEnd;
      // clear acts on the command byte alone
      wire       clrReq  = cmdDone & (nextIn == `SFRC_CMD_CLR_FLAG);
      // exact bit count at chip select rise
      wire       lenOk   = (cmd == `SFRC_CMD_WR_NVCFG) ?
                           (bitCnt == `SFRC_NVCFG_BITS) :
                           (bitCnt == `SFRC_BYTE_BITS);
      wire       wrEnd   = csRise & (state == ST_WDATA);
      wire       wrGo    = wrEnd & lenOk & wel & ~wip;
      // lock bit with write-protect pin low
      wire       srBlock = (cmd == `SFRC_CMD_WR_STATUS) &
                           srHi[`SFRC_SR_LOCK] & ~wpS;
      wire       wrExec  = wrGo & ~srBlock;
      wire       argEnd  = csRise & (state == ST_NOARG) &
                           (bitCnt == 6'h00);
      wire       busyEnd = wip & (busyCnt == `SFRC_CNT_DONE);

      // --------------------------------------------------------
      // command decode and shifting
      always @(posedge ref_clk) begin
        if (rst) begin
          state  <= ST_SKIP;
          cmd    <= 8'h00;
          inSr   <= 8'h00;
          bitCnt <= 6'h00;
          dataLo <= 8'h00;
          dataHi <= 8'h00;
          outSr  <= 8'h00;
          outCnt <= 3'h0;
          outIdx <= 2'h0;
          doutR  <= 4'h0;
          oeR    <= 4'h0;
        end else if (csFall) begin
          state  <= ST_CMD;
          bitCnt <= 6'h00;
          oeR    <= 4'h0;
        end else if (csRise | csS) begin
          // drop the drive when chip select rises
          state <= ST_SKIP;
          oeR   <= 4'h0;
        end else if (linkRise && state != ST_READ) begin
          inSr <= nextIn;
          if (state == ST_CMD && byteEnd) begin
            cmd    <= nextIn;
            bitCnt <= 6'h00;
            outSr  <= readByte(nextIn, 2'h0, status, flag, nvReg,
                               vcReg, ecReg);
            outIdx <= 2'h1;
            outCnt <= 3'h0;
            case (nextIn)
              `SFRC_CMD_RD_STATUS, `SFRC_CMD_RD_FLAG,
              `SFRC_CMD_RD_NVCFG, `SFRC_CMD_RD_VCFG,
              `SFRC_CMD_RD_ECFG:  state <= ST_READ;
              `SFRC_CMD_WR_STATUS, `SFRC_CMD_WR_NVCFG,
              `SFRC_CMD_WR_VCFG, `SFRC_CMD_WR_ECFG:
                                  state <= ST_WDATA;
              `SFRC_CMD_WR_EN, `SFRC_CMD_WR_DIS:
                                  state <= ST_NOARG;
              default:            state <= ST_SKIP;
            endcase
          end else begin
            if (bitCnt < `SFRC_BIT_SAT)
              bitCnt <= bitSum;
            // first data byte is the low byte
            if (state == ST_WDATA && byteEnd) begin
              if (bitCnt < `SFRC_BYTE_BITS)
                dataLo <= nextIn;
              else if (bitCnt < `SFRC_NVCFG_BITS)
                dataHi <= nextIn;
            end
          end
        end else if (linkFall && state == ST_READ) begin
          doutR  <= outBits(outSr, protoMode);
          oeR    <= oeMask(protoMode);
          outCnt <= outSum[2:0];
          if (outSum[3]) begin
            outSr <= readByte(cmd, outIdx, status, flag, nvReg,
                              vcReg, ecReg);
            if (outIdx != `SFRC_IDX_SAT)
              outIdx <= outIdx + 2'h1;
          end else begin
            outSr <= shiftOut(outSr, protoMode);
          end
        end
      end

      // --------------------------------------------------------
      // register state, latch and self-timed writes
      always @(posedge ref_clk) begin
        if (rst) begin
          srHi    <= `SFRC_SR_RST;
          wel     <= 1'b0;
          wip     <= 1'b0;
          busyNv  <= 1'b0;
          busyCnt <= 24'h000000;
          fsErase <= 1'b0;
          fsProg  <= 1'b0;
          fsProt  <= 1'b0;
          nvReg   <= `SFRC_NVCFG_RST;
          vcReg   <= `SFRC_VCFG_RST;
          ecReg   <= `SFRC_ECFG_RST;
        end else begin
          // clear errors, a new error in the same cycle wins
          fsErase <= (fsErase & ~clrReq) | eraseErr[d];
          fsProg  <= (fsProg & ~clrReq) | progErr[d];
          fsProt  <= (fsProt & ~clrReq) | (wrGo & srBlock);
          // a write or latch command of wrong length leaves latch and flags untouched
          if (argEnd && cmd == `SFRC_CMD_WR_EN)
            wel <= 1'b1;
          else if (argEnd && cmd == `SFRC_CMD_WR_DIS && !fsProt)
            wel <= 1'b0;
          // latch cleared when the write completes
          else if (busyEnd)
            wel <= 1'b0;
          else if (wrExec && (cmd == `SFRC_CMD_WR_VCFG ||
                              cmd == `SFRC_CMD_WR_ECFG))
            wel <= 1'b0;
          if (wrExec && (cmd == `SFRC_CMD_WR_STATUS ||
                         cmd == `SFRC_CMD_WR_NVCFG)) begin
            wip    <= 1'b1;
            busyNv <= (cmd == `SFRC_CMD_WR_NVCFG);
            busyCnt <= (cmd == `SFRC_CMD_WR_NVCFG) ?
                       TNV_CYC[23:0] : TW_CYC[23:0];
          end else if (busyEnd) begin
            wip <= 1'b0;
            busyCnt <= 24'h000000;
            if (busyNv)
              nvReg <= {dataHi, dataLo};
            else
              srHi <= dataLo[7:2];
          end else if (wip) begin
            busyCnt <= busyCnt - `SFRC_CNT_DONE;
          end
          if (wrExec && cmd == `SFRC_CMD_WR_VCFG)
            vcReg <= (dataLo & ~`SFRC_VCFG_RSV) |
                     (vcReg & `SFRC_VCFG_RSV);
          if (wrExec && cmd == `SFRC_CMD_WR_ECFG)
            ecReg <= (dataLo & ~`SFRC_ECFG_RSV) |
                     (ecReg & `SFRC_ECFG_RSV);
        end
      end

      assign dqOut[4*d+3:4*d]    = doutR;
      assign dqOe[4*d+3:4*d]     = oeR;
      assign regStatus[8*d+7:8*d] = status;
      assign regFlag[8*d+7:8*d]   = flag;
      assign cfgNv[16*d+15:16*d]  = nvReg;
      assign cfgVol[8*d+7:8*d]    = vcReg;
      assign cfgEnh[8*d+7:8*d]    = ecReg;
    end
  endgenerate

endmodule

`default_nettype wire

// ### testbench/sfrc_monitor.sv
// assertion checker for the register command block
`timescale 1ns/1ps
`default_nettype none
`include "sfrc_map.vh"
module sfrc_monitor #(
  parameter STATUS_WRITE_TIME_NS = 50000,
  parameter CONFIG_WRITE_TIME_NS = 80000
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // link and events
  input wire logic        chipSelN,
  input wire logic [7:0]  dqOe,
  input wire logic [1:0]  protoMode,
  input wire logic [1:0]  memBusy,
  input wire logic [1:0]  eraseErr,
  input wire logic [1:0]  progErr,
  // registers
  input wire logic [15:0] regStatus,
  input wire logic [15:0] regFlag,
  input wire logic [31:0] cfgNv
);
  localparam int SW_CYC = (STATUS_WRITE_TIME_NS + 9) / 10;
  localparam int NV_CYC = (CONFIG_WRITE_TIME_NS + 9) / 10;
  logic [16:0] wipCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // busy run length of die 0, zeroed whenever idle
  always @(posedge ref_clk) begin
    if (rst || !regStatus[0]) wipCnt <= 17'h0;
    else wipCnt <= wipCnt + 17'h1;
  end
  AST_RELEASE: assert property ($rose(chipSelN) |->
    ##[1:6] dqOe == 8'h00)
    else $error("lanes still driven after deselect");
  AST_IDLE: assert property (chipSelN [*8] |-> dqOe == 8'h00)
    else $error("lanes driven while deselected");
  AST_EXT_LANES: assert property (protoMode == `SFRC_MODE_EXT |->
    (dqOe & 8'hDD) == 8'h00) else $error("wrong lane in single mode");
  AST_DUAL_LANES: assert property (protoMode == `SFRC_MODE_DUAL |->
    (dqOe & 8'hCC) == 8'h00) else $error("wrong lane in dual mode");
  AST_WEL_SET: assert property ($rose(regStatus[1]) |->
    chipSelN && $past(chipSelN, 2)) else $error("latch set while selected");
  AST_SR_TIMED: assert property ($changed(regStatus[7:2]) |->
    $past(regStatus[0])) else $error("status bits changed untimed");
  AST_NV_TIMED: assert property ($changed(cfgNv[15:0]) |->
    $past(regStatus[0])) else $error("config changed untimed");
  AST_WIP_SPAN: assert property ($fell(regStatus[0]) && !memBusy[0] |->
    wipCnt >= SW_CYC - 1 && wipCnt <= NV_CYC + 2)
    else $error("busy span out of range");
  AST_ERASE_SET: assert property (eraseErr[0] |=> regFlag[5])
    else $error("erase error not flagged");
  AST_PROG_SET: assert property (progErr[1] |=> regFlag[12])
    else $error("program error not flagged on die 1");
  AST_BUSY: assert property (memBusy[1] && $past(memBusy[1]) |->
    !regFlag[15] && regStatus[8]) else $error("busy not reported");
  cover property ($fell(regStatus[0]));
  cover property ($rose(dqOe[5]));
  cover property ($rose(regFlag[1]));
endmodule
bind sfrc_top sfrc_monitor #(
  .STATUS_WRITE_TIME_NS(STATUS_WRITE_TIME_NS),
  .CONFIG_WRITE_TIME_NS(CONFIG_WRITE_TIME_NS)
) mon (.ref_clk(ref_clk), .rst(rst), .chipSelN(chipSelN), .dqOe(dqOe),
  .protoMode(protoMode), .memBusy(memBusy), .eraseErr(eraseErr),
  .progErr(progErr), .regStatus(regStatus), .regFlag(regFlag),
  .cfgNv(cfgNv));
`default_nettype wire

// ### testbench/sfrc_host.sv
// host controller model driving the link pins
`timescale 1ns/1ps
`default_nettype none
module sfrc_host (
  // clock
  input  wire logic       ref_clk,
  // link pins
  input  wire logic [7:0] dqOut,
  input  wire logic [7:0] dqOe,
  output var  logic       linkClk,
  output var  logic       chipSelN,
  output wire logic [7:0] dqIn
);
  logic [7:0] hDq;
  logic [7:0] hOe;
  logic       tog;
  // released lanes toggle so a stale level never passes for data
  assign dqIn = (dqOe & dqOut) | (~dqOe & hOe & hDq) |
                (~dqOe & ~hOe & {8{tog}});
  initial begin
    linkClk = 1'b0;
    chipSelN = 1'b1;
    hDq = 8'h00;
    hOe = 8'h00;
    tog = 1'b0;
  end
  always @(posedge ref_clk) begin
    tog <= ~tog;
  end
  task automatic xfer(input logic [1:0] m, input logic [23:0] w,
    input int nb, input int rb, output logic [23:0] r0, r1);
    int bp;
    logic [23:0] sh;
    logic [7:0] s;
    bp = (m == 2'h0) ? 1 : (m == 2'h1) ? 2 : 4;
    r0 = 24'h0;
    r1 = 24'h0;
    chipSelN = 1'b0;
    #62.5;
    for (int k = 0; k < nb; k += bp) begin
      sh = w << k;
      // same bits on both lane groups, msb first
      hOe = {2{4'hF >> (4 - bp)}};
      hDq = {2{sh[23:20] >> (4 - bp)}};
      #62.5 linkClk = 1'b1;
      #62.5 linkClk = 1'b0;
    end
    hOe = 8'h00;
    for (int k = 0; k < rb; k += bp) begin
      #62.5 linkClk = 1'b1;
      s = dqIn >> (m == 2'h0);
      r0 = (r0 << bp) | 24'(s[3:0] & (4'hF >> (4 - bp)));
      r1 = (r1 << bp) | 24'(s[7:4] & (4'hF >> (4 - bp)));
      #62.5 linkClk = 1'b0;
    end
    #62.5 chipSelN = 1'b1;
    #60;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the register command block
`timescale 1ns/1ps
`default_nettype none
`include "sfrc_map.vh"
module tb;
  logic        ref_clk;
  logic        rst;
  logic        writeProtN;
  logic [1:0]  protoMode;
  logic [1:0]  memBusy;
  logic [1:0]  eraseErr;
  logic [1:0]  progErr;
  wire  logic       linkClk;
  wire  logic       chipSelN;
  wire  logic [7:0] dqIn;
  wire  logic [7:0] dqOut;
  wire  logic [7:0] dqOe;
  wire  logic [15:0] regStatus;
  wire  logic [15:0] regFlag;
  wire  logic [31:0] cfgNv;
  wire  logic [15:0] cfgVol;
  wire  logic [15:0] cfgEnh;
  int          err_total;
  int          compares;
  logic [23:0] r0;
  logic [23:0] r1;
  logic [7:0]  d;
  logic [7:0]  vol;
  logic [7:0]  enh;
  logic [15:0] nv;
  // short timers keep the run brief but longer than a status read
  sfrc_top #(.STATUS_WRITE_TIME_NS(3000), .CONFIG_WRITE_TIME_NS(4000)) uut (
    .ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .chipSelN(chipSelN),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .writeProtN(writeProtN),
    .protoMode(protoMode), .memBusy(memBusy), .eraseErr(eraseErr),
    .progErr(progErr), .regStatus(regStatus), .regFlag(regFlag),
    .cfgNv(cfgNv), .cfgVol(cfgVol), .cfgEnh(cfgEnh));
  sfrc_host host (.ref_clk(ref_clk), .dqOut(dqOut), .dqOe(dqOe),
    .linkClk(linkClk), .chipSelN(chipSelN), .dqIn(dqIn));
  always #5 ref_clk = ~ref_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [15:0] nvrd(input logic [15:0] v);
    logic [15:0] f;
    f = v | `SFRC_NVCFG_RSV;
    return {f[7:0], f[15:8]};
  endfunction
  task automatic cmd(input logic [23:0] w, input int nb, input int rb);
    host.xfer(protoMode, w, nb, rb, r0, r1);
  endtask
  task automatic wren();
    cmd({`SFRC_CMD_WR_EN, 16'h0000}, 8, 0);
  endtask
  task automatic setm(input logic [1:0] m);
    @(posedge ref_clk) protoMode <= m;
    @(posedge ref_clk);
  endtask
  task automatic poll();
    for (int i = 0; i < 2000; i++) begin
      if ((regStatus & 16'h0101) === 16'h0000) break;
      @(posedge ref_clk);
    end
    #1;
    check(regStatus & 16'h0101, 16'h0000);
  endtask
  task automatic swrite(input logic [7:0] v);
    wren();
    cmd({`SFRC_CMD_WR_STATUS, v, 8'h00}, 16, 0);
    poll();
  endtask
  task automatic vtest(input logic [7:0] wc, input logic [7:0] rc,
    input logic [7:0] rsv, input logic sel, inout logic [7:0] mdl);
    logic [7:0] v;
    v = 8'($urandom);
    mdl = (v & ~rsv) | (mdl & rsv);
    wren();
    check(regStatus & 16'h0202, 16'h0202);
    cmd({wc, v, 8'h00}, 16, 0);
    check(sel ? cfgEnh : cfgVol, {mdl, mdl});
    cmd({rc, 16'h0000}, 8, 24);
    check(r0[23:8], {mdl, mdl});
    check(r1[15:0], {mdl, mdl});
  endtask
  initial begin
    #800000;
    err_total++;
    close_out();
  end
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    writeProtN = 1'b1;
    protoMode = `SFRC_MODE_EXT;
    memBusy = 2'h0;
    eraseErr = 2'h0;
    progErr = 2'h0;
    err_total = 0;
    compares = 0;
    vol = `SFRC_VCFG_RST;
    enh = `SFRC_ECFG_RST;
    d = 8'($urandom(73));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    check(regStatus, 16'h0000);
    check(regFlag, 16'h8080);
    check(cfgNv[15:0], `SFRC_NVCFG_RST);
    for (int m = 0; m < 3; m++) begin
      setm(2'(m));
      vtest(`SFRC_CMD_WR_VCFG, `SFRC_CMD_RD_VCFG, `SFRC_VCFG_RSV, 1'b0, vol);
      vtest(`SFRC_CMD_WR_ECFG, `SFRC_CMD_RD_ECFG, `SFRC_ECFG_RSV, 1'b1, enh);
    end
    setm(`SFRC_MODE_EXT);
    d = 8'($urandom) & 8'h7F;
    wren();
    cmd({`SFRC_CMD_WR_STATUS, d, 8'h00}, 16, 0);
    cmd({`SFRC_CMD_RD_STATUS, 16'h0000}, 8, 8);
    check({r1[7:0], r0[7:0]}, 16'h0303);
    poll();
    check(regStatus, {2{d[7:2], 2'b00}});
    cmd({`SFRC_CMD_RD_STATUS, 16'h0000}, 8, 16);
    check(r0[15:0], {2{d[7:2], 2'b00}});
    swrite(8'h80);
    @(posedge ref_clk) writeProtN <= 1'b0;
    wren();
    cmd({`SFRC_CMD_WR_STATUS, 16'h0000}, 16, 0);
    check(regStatus, 16'h8282);
    check(regFlag, 16'h8282);
    cmd({`SFRC_CMD_WR_DIS, 16'h0000}, 8, 0);
    check(regStatus, 16'h8282);
    cmd({`SFRC_CMD_CLR_FLAG, 16'h0000}, 8, 0);
    check(regFlag, 16'h8080);
    cmd({`SFRC_CMD_WR_DIS, 16'h0000}, 8, 0);
    check(regStatus, 16'h8080);
    @(posedge ref_clk) writeProtN <= 1'b1;
    swrite(8'h00);
    wren();
    cmd({`SFRC_CMD_WR_VCFG, 16'h0000}, 20, 0);
    cmd({`SFRC_CMD_WR_NVCFG, 16'h0000}, 16, 0);
    check(regStatus, 16'h0202);
    check(regFlag, 16'h8080);
    check(cfgVol, {vol, vol});
    nv = 16'($urandom);
    cmd({`SFRC_CMD_WR_NVCFG, nv[7:0], nv[15:8]}, 24, 0);
    poll();
    check(cfgNv[15:0] | `SFRC_NVCFG_RSV, nv | `SFRC_NVCFG_RSV);
    check(regStatus, 16'h0000);
    setm(`SFRC_MODE_QUAD);
    cmd({`SFRC_CMD_RD_NVCFG, 16'h0000}, 8, 24);
    check(r0[23:8], nvrd(nv));
    check(r1[23:8], nvrd(nv));
    check({r1[7:0], r0[7:0]}, 16'h0000);
    @(posedge ref_clk) begin
      eraseErr <= 2'h1;
      progErr <= 2'h2;
    end
    @(posedge ref_clk) begin
      eraseErr <= 2'h0;
      progErr <= 2'h0;
      memBusy <= 2'h2;
    end
    repeat (4) @(posedge ref_clk);
    #1;
    check(regFlag, 16'h10A0);
    check(regStatus, 16'h0100);
    @(posedge ref_clk) memBusy <= 2'h0;
    cmd({`SFRC_CMD_CLR_FLAG, 16'h0000}, 12, 0);
    check(regFlag, 16'h8080);
    setm(`SFRC_MODE_EXT);
    cmd({`SFRC_CMD_RD_STATUS, 16'h0000}, 8, 3);
    check({8'h00, dqOe}, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
